// ---- hw/adcpp_pkg.sv ----
`default_nettype none

package adcpp_pkg;

  // ****************************************
  // Data word layout
  // ****************************************
  localparam int WORD_W = 12;
  localparam int BUS_W = 12;
  localparam int CHAN_W = 3;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 4;
  localparam int CHAN_LSB = 4;
  localparam int BIT8_POS = 8;
  localparam int TEN_PAD = 2;
  localparam logic [11:0] WORD_RESET = 12'h000;

  // ****************************************
  // Timing (50 MHz clock)
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int QUIET_NS = 30;
  localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus phase of the port
  typedef enum logic [1:0] {
    ADCPP_IDLE = 2'b00,
    ADCPP_READ = 2'b01,
    ADCPP_WRITE = 2'b10
  } adcpp_phase_t;

endpackage

`default_nettype wire

// ---- hw/adcpp_buf_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Result stream between source and buffer
// ****************************************
interface adcpp_buf_if;
  logic valid;
  logic ready;
  logic [11:0] word;
  logic [2:0] chan;
  modport src (output valid, output word, output chan, input ready);
  modport snk (input valid, input word, input chan, output ready);
endinterface : adcpp_buf_if

`default_nettype wire

// ---- hw/adcpp_buf.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Two-entry skid buffer for results
// ****************************************
module adcpp_buf (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Upstream and downstream
  adcpp_buf_if.snk in_s,
  output logic out_valid,
  input wire logic out_ready,
  output logic [11:0] out_word,
  output logic [2:0] out_chan
);
  logic [14:0] mem [0:1];
  logic wp;
  logic rp;
  logic [1:0] count;
  logic push;
  logic pop;

  // Full buffer stalls the source
  assign in_s.ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid && out_ready;
  assign out_word = mem[rp][11:0];
  assign out_chan = mem[rp][14:12];

  // Storage writes
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp] <= {in_s.chan, in_s.word};
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk) begin
    if (reset) begin
      wp <= 1'b0;
      rp <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  no_overflow_a : assert property (@(posedge mclk) disable iff (reset)
    count <= 2'd2) else $error("buffer overfilled");

endmodule // adcpp_buf

`default_nettype wire

// ---- hw/adcpp_port.sv ----
`timescale 1ns/1ns
`default_nettype none

// Function
// - Low data lines read results, take writes
// - Ten-bit word and low-byte reads zero two lowest lines
// - Word mode: shared pin is bit 8
// - Byte mode: shared pin selects byte
// - Low byte travels on lines 0-7
// - High byte's four bits on 0-3
// - High-byte read shows channel on 4-6
// - Ten-bit low byte: two zero bits
// - Word mode lines 9-11 carry data
// - Drive result after read strobe falls
module adcpp_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Configuration
  input wire logic ten_bit,
  input wire logic word_mode,
  // Host strobes (active low)
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // Data lines 0-7 and 9-11 (bit 8 unused here)
  input wire logic [11:0] db_in,
  output logic [11:0] db_out,
  output logic [11:0] db_oe,
  // Shared bit8_or_byte_select pin
  input wire logic bit8_or_byte_select_in,
  output logic bit8_or_byte_select_out,
  output logic bit8_or_byte_select_oe,
  // Result stream from the converter
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [11:0] res_word,
  input wire logic [2:0] res_chan,
  // Register programming output
  output logic prog_valid,
  output logic [11:0] prog_word,
  output logic prog_high
);
  adcpp_buf_if bus_i ();
  logic buf_valid;
  logic buf_ready;
  logic [11:0] buf_word;
  logic [2:0] buf_chan;
  adcpp_pkg::adcpp_phase_t phase;
  adcpp_pkg::adcpp_phase_t next_phase;
  logic read_act;
  logic write_act;
  logic high_byte_select;
  logic [11:0] held_word;
  logic [2:0] held_chan;
  logic [11:0] rd_word;
  logic [11:0] next_drive;
  logic [11:0] drive;
  logic [11:0] low_acc;

  // ****************************************
  // Result buffering
  // ****************************************
  assign bus_i.valid = res_valid;
  assign bus_i.word = res_word;
  assign bus_i.chan = res_chan;
  assign res_ready = bus_i.ready;

  adcpp_buf u_buf (
    .mclk(mclk),
    .reset(reset),
    .in_s(bus_i),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_word(buf_word),
    .out_chan(buf_chan)
  );

  // ****************************************
  // Strobe decode
  // ****************************************
  // Byte select only exists in byte mode
  assign high_byte_select = !word_mode && bit8_or_byte_select_in;
  assign read_act = !cs_n && !rd_n;
  assign write_act = !cs_n && !wr_n && rd_n;

  // Phase tracking
  always_comb begin
    next_phase = adcpp_pkg::ADCPP_IDLE;
    if (read_act) begin
      next_phase = adcpp_pkg::ADCPP_READ;
    end else if (write_act) begin
      next_phase = adcpp_pkg::ADCPP_WRITE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      phase <= adcpp_pkg::ADCPP_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Pop a result once it has been fully read; word read or high byte ends it
  assign buf_ready = (phase == adcpp_pkg::ADCPP_READ) && !read_act
    && (word_mode || high_byte_select);

  // Oldest queued result held so repeated reads return stable data
  always_ff @(posedge mclk) begin
    if (reset) begin
      held_word <= adcpp_pkg::WORD_RESET;
      held_chan <= 3'h0;
    end else if (buf_valid && phase == adcpp_pkg::ADCPP_IDLE && !read_act) begin
      held_word <= buf_word;
      held_chan <= buf_chan;
    end
  end

  // ****************************************
  // Read data mapping
  // ****************************************
  // Ten-bit variant pads the two LSBs with zeros
  always_comb begin
    rd_word = held_word;
    if (ten_bit) begin
      rd_word[adcpp_pkg::TEN_PAD-1:0] = 2'b00;
    end
    next_drive = 12'h000;
    if (word_mode) begin
      next_drive = rd_word;
    end else if (high_byte_select) begin
      next_drive[adcpp_pkg::HIGH_W-1:0] = rd_word[11:8];
      next_drive[6:4] = held_chan;
    end else begin
      next_drive[adcpp_pkg::LOW_W-1:0] = rd_word[7:0];
    end
  end

  // Data outputs registered; one cycle access at 50 MHz
  always_ff @(posedge mclk) begin
    if (reset) begin
      drive <= 12'h000;
    end else if (read_act) begin
      drive <= next_drive;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Enables are combinational so the bus floats as soon as strobes drop
  always_comb begin
    db_out = drive;
    db_oe = 12'h000;
    if (read_act && phase == adcpp_pkg::ADCPP_READ) begin
      db_oe = word_mode ? 12'hfff : 12'h0ff;
    end
    db_oe[adcpp_pkg::BIT8_POS] = 1'b0;
  end
  assign bit8_or_byte_select_out = drive[adcpp_pkg::BIT8_POS];
  assign bit8_or_byte_select_oe = word_mode && read_act
    && (phase == adcpp_pkg::ADCPP_READ);

  // ****************************************
  // Write capture
  // ****************************************
  // Data latched on the rising edge of the write strobe
  always_comb begin
    low_acc = db_in;
    low_acc[adcpp_pkg::BIT8_POS] = bit8_or_byte_select_in;
    if (!word_mode) begin
      low_acc[11:8] = 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prog_valid <= 1'b0;
      prog_word <= 12'h000;
      prog_high <= 1'b0;
    end else begin
      prog_valid <= 1'b0;
      if (phase == adcpp_pkg::ADCPP_WRITE && !write_act) begin
        prog_valid <= 1'b1;
        prog_word <= low_acc;
        prog_high <= high_byte_select;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  float_idle_a : assert property (@(posedge mclk) disable iff (reset)
    !read_act |-> (db_oe == 12'h000)) else $error("bus driven without read");

  ten_pad_a : assert property (@(posedge mclk) disable iff (reset)
    (read_act && ten_bit && !high_byte_select) ##1 read_act |-> drive[1:0] == 2'b00)
    else $error("ten-bit pad not zero");

  chan_id_a : assert property (@(posedge mclk) disable iff (reset)
    read_act && high_byte_select |=> drive[6:4] == $past(held_chan))
    else $error("channel id missing");

  high_nib_a : assert property (@(posedge mclk) disable iff (reset)
    read_act && high_byte_select |=> drive[11:7] == 5'h00)
    else $error("high byte upper lines not zero");

  low_byte_a : assert property (@(posedge mclk) disable iff (reset)
    read_act && !word_mode && !high_byte_select |=> drive[11:8] == 4'h0)
    else $error("low byte leaks upper bits");

  bit8_pin_a : assert property (@(posedge mclk) disable iff (reset)
    !word_mode |-> !bit8_or_byte_select_oe) else $error("select pin driven");

  word_read_a : assert property (@(posedge mclk) disable iff (reset)
    read_act && word_mode && !ten_bit |=> drive == $past(held_word))
    else $error("word read mismatch");

  drive_late_a : assert property (@(posedge mclk) disable iff (reset)
    $fell(rd_n) && !cs_n |-> db_oe == 12'h000) else $error("drove before read");

  write_pulse_a : assert property (@(posedge mclk) disable iff (reset)
    phase == adcpp_pkg::ADCPP_WRITE && !write_act |=> prog_valid)
    else $error("write not captured");

endmodule // adcpp_port

`default_nettype wire

// ---- verification/adcpp_host.sv ----
`timescale 1ns/1ns
`default_nettype none

// ********
// Host bus master model
// ********
module adcpp_host (
  // Clock and mode
  input wire logic mclk,
  input wire logic wm,
  // Device drive
  input wire logic [11:0] db_out,
  input wire logic [11:0] db_oe,
  input wire logic b8_out,
  input wire logic b8_oe,
  // Strobes and bus
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [11:0] db_in,
  output logic h_b8
);
  // Idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    db_in = 12'h000;
    h_b8 = 1'b0;
  end

  // Read: strobes held four edges, sampled settled after the third
  task automatic rd(input logic s, output logic [11:0] d, output logic [11:0] oe);
    @(posedge mclk);
    h_b8 <= s;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    d = {db_out[11:9], b8_out, db_out[7:0]};
    oe = {db_oe[11:9], b8_oe, db_oe[7:0]};
    @(posedge mclk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // Write: data held one cycle past the strobe for hold time
  task automatic wr(input logic s, input logic [11:0] v);
    @(posedge mclk);
    h_b8 <= wm ? v[8] : s;
    db_in <= v;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (2) @(posedge mclk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge mclk);
    db_in <= ~v; // Released bus must not show the old word
  endtask
endmodule // adcpp_host

`default_nettype wire

// ---- verification/adc_parallel_data_bus_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module adc_parallel_data_bus_port_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ten_bit = 1'b0;
  logic word_mode = 1'b1;
  logic res_valid = 1'b0;
  logic [11:0] res_word = 12'h000;
  logic [2:0] res_chan = 3'h0;
  wire logic cs_n, rd_n, wr_n, h_b8, b8_out, b8_oe, res_ready, prog_valid, prog_high;
  wire logic [11:0] db_in, db_out, db_oe, prog_word;
  wire logic pin = b8_oe ? b8_out : h_b8; // Shared pin level
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [11:0] d, oe;
  typedef struct packed {logic ten; logic [11:0] w; logic [2:0] c;} adcpp_row_t;
  adcpp_row_t rows [4] = '{'{1'b0, 12'ha5c, 3'h3}, '{1'b1, 12'h5a7, 3'h6},
                           '{1'b0, 12'hfff, 3'h7}, '{1'b1, 12'h001, 3'h0}};

  // Clock, 20 ns period
  always #10 mclk = ~mclk;

  adcpp_port u_dut (.mclk(mclk), .reset(reset), .ten_bit(ten_bit), .word_mode(word_mode),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .bit8_or_byte_select_in(pin), .bit8_or_byte_select_out(b8_out),
    .bit8_or_byte_select_oe(b8_oe), .res_valid(res_valid), .res_ready(res_ready),
    .res_word(res_word), .res_chan(res_chan), .prog_valid(prog_valid),
    .prog_word(prog_word), .prog_high(prog_high));

  adcpp_host u_host (.mclk(mclk), .wm(word_mode), .db_out(db_out), .db_oe(db_oe),
    .b8_out(b8_out), .b8_oe(b8_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .db_in(db_in), .h_b8(h_b8));

  // ********
  // Checking helpers
  // ********
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Offer one result, waiting out a full buffer
  task automatic push(input logic [11:0] w, input logic [2:0] c);
    @(posedge mclk);
    res_valid <= 1'b1;
    res_word <= w;
    res_chan <= c;
    for (int i = 0; i < 20; i++) begin
      @(negedge mclk);
      if (res_ready === 1'b1) break;
    end
    @(posedge mclk);
    res_valid <= 1'b0;
  endtask

  // Expect one programming pulse; word mode ignores the byte flag
  task automatic wprog(input logic [11:0] w, input logic h);
    for (int i = 0; i < 10 && prog_valid !== 1'b1; i++) @(negedge mclk);
    chk("prog_word", prog_word, w);
    chk("prog_flag", {10'h0, prog_valid, prog_high | word_mode}, {10'h0, 1'b1, h});
    @(negedge mclk);
    chk("prog_pulse", {11'h0, prog_valid}, 12'h000);
    @(posedge mclk);
  endtask

  // Hang guard, far above the expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      give_verdict;
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      ten_bit <= rows[i].ten;
      push(rows[i].w, rows[i].c);
      repeat (3) @(posedge mclk);
      u_host.rd(1'b0, d, oe);
      chk("word", d, rows[i].ten ? rows[i].w & 12'hffc : rows[i].w);
      chk("word_oe", oe, 12'hfff);
      #1;
      chk("idle_oe", {db_oe[11:1], b8_oe}, 12'h000);
    end
    // Byte mode, ten-bit: low byte then high byte
    word_mode <= 1'b0;
    push(12'hc3b, 3'h5);
    repeat (3) @(posedge mclk);
    u_host.rd(1'b0, d, oe);
    chk("low", {4'h0, d[7:0]}, 12'h038);
    chk("byte_oe", oe & 12'h1ff, 12'h0ff);
    u_host.rd(1'b1, d, oe);
    chk("high", {4'h0, d[7:0]}, 12'h05c);
    chk("high_oe", oe & 12'h1ff, 12'h0ff);
    // Writes in byte mode, then word mode with bit 8 set
    u_host.wr(1'b0, 12'h07e);
    wprog(12'h07e, 1'b0);
    u_host.wr(1'b1, 12'h00a);
    wprog(12'h00a, 1'b1);
    word_mode <= 1'b1;
    ten_bit <= 1'b0;
    u_host.wr(1'b0, 12'h9c3);
    wprog(12'h9c3, 1'b1);
    // Fill both entries, then drain in order
    push(12'h123, 3'h1);
    push(12'h456, 3'h2);
    @(negedge mclk);
    chk("full", {11'h0, res_ready}, 12'h000);
    u_host.rd(1'b0, d, oe);
    chk("first", d, 12'h123);
    u_host.rd(1'b0, d, oe);
    chk("second", d, 12'h456);
    chk("empty", {11'h0, res_ready}, 12'h001);
    // Reset in mid-run drops the queued result
    push(12'h777, 3'h4);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk("rst", {prog_valid, res_ready, db_oe[9:0]}, 12'h400);
    u_host.rd(1'b0, d, oe);
    chk("rst_word", d, 12'h000);
    give_verdict;
  end
endmodule // adc_parallel_data_bus_port_tb

`default_nettype wire
